// ==== dv/p7g_board.sv ====
// Board model standing on the pins of the port block.
// Assumes the bench picks the level of every pin the device releases.
module p7g_board (
  // Device drive
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  // Board level and resolved pin
  input  wire [7:0] board_val,
  output wire [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the device level; a released one shows the board level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_val);
endmodule

// ==== dv/p7g_port_properties.sv ====
// Checker of bus and pin timing for the port block.
// Assumes it is bound to p7g_port and sees only its ports.
`include "p7g_consts.vh"
module p7g_chk (
  // Clock and reset
  input wire        MCLK,
  input wire        RST_N,
  // Bus
  input wire [7:0]  S_AXI_AWADDR,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [7:0]  S_AXI_ARADDR,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  // Pins and power
  input wire [7:0]  PORT_PIN_OUT,
  input wire [7:0]  PORT_PIN_OE,
  input wire [2:0]  POWER_STATE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  reg [7:0] aw_q;
  wire      ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  // Keep the write address, since the response may come cycles later.
  always @(posedge MCLK or negedge RST_N)
    if (!RST_N) aw_q <= 8'h00;
    else if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_rdlat; ar_hs |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h000000; endproperty
  a_rdlat: assert property (p_rdlat) else $error("read answer late or wide");
  property p_bresp;
    $rose(S_AXI_BVALID) |-> S_AXI_BRESP == ((aw_q > 8'h18 || aw_q[1:0] != 2'h0) ? 2'h2 : 2'h0);
  endproperty
  a_bresp: assert property (p_bresp) else $error("wrong write response code");
  property p_rmfix; ar_hs && S_AXI_ARADDR == `P7G_ADDR_REALTIME_MODE |=> S_AXI_RDATA[3:0] == 4'hF; endproperty
  a_rmfix: assert property (p_rmfix) else $error("mode low nibble not ones");
  property p_dirro; ar_hs && S_AXI_ARADDR == `P7G_ADDR_PIN_DIRECTION |=> S_AXI_RDATA[7:0] == 8'hFF; endproperty
  a_dirro: assert property (p_dirro) else $error("direction read not all ones");
  property p_egfix; ar_hs && S_AXI_ARADDR == `P7G_ADDR_TRIGGER_EDGE |=> S_AXI_RDATA[7:2] == 6'h3F; endproperty
  a_egfix: assert property (p_egfix) else $error("edge upper bits not ones");
  property p_stby; (POWER_STATE == `P7G_PWR_STANDBY)[*5] |-> PORT_PIN_OE == 8'h00; endproperty
  a_stby: assert property (p_stby) else $error("pins driven in standby");
  property p_hold; (POWER_STATE == `P7G_PWR_SLEEP)[*5] |=> $stable(PORT_PIN_OUT) && $stable(PORT_PIN_OE); endproperty
  a_hold: assert property (p_hold) else $error("pins moved in sleep");
endmodule
bind p7g_port p7g_chk chk (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PORT_PIN_OUT(PORT_PIN_OUT),
  .PORT_PIN_OE(PORT_PIN_OE), .POWER_STATE(POWER_STATE));

// ==== dv/port7_gpio_realtime_output_bench.sv ====
// Bench of the port block: registers, pin modes, realtime triggers, power states.
// Assumes the board model resolves released pins to the level in brd.
`include "p7g_consts.vh"
module port7_gpio_realtime_output_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         mclk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0;
  reg         arv = 1'h0, rry = 1'h0, ext = 1'h0, head_switch_trigger = 1'h0;
  reg  [7:0]  awa = 8'h00, ara = 8'h00, brd = 8'h5A, pg = 8'h00, lf = 8'h0D;
  reg  [7:0]  ps = 8'h00, rm = 8'h0F, dir = 8'h00, lat = 8'h00, src = 8'h0F, sd = 8'h00, sdr = 8'h00;
  reg  [31:0] wd = 32'h00000000;
  reg  [2:0]  pwr = 3'h0;
  reg  [1:0]  eg = 2'h0;
  reg  [15:0] snap;
  integer     mismatches = 0, tests_run = 0, cyc = 0, i;
  wire        awr, wr, bv, arr, rv;
  wire [1:0]  br, rr;
  wire [31:0] rd;
  wire [7:0]  po, poe, pin;
  p7g_port uut (.MCLK(mclk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .PORT_PIN_IN(pin),
    .PORT_PIN_OUT(po), .PORT_PIN_OE(poe), .PATTERN_GENERATOR_OUTPUT(pg),
    .EXTERNAL_TRIGGER_PIN(ext), .HEAD_SWITCH_TRIGGER(head_switch_trigger), .POWER_STATE(pwr));
  p7g_board board (.pin_out(po), .pin_oe(poe), .board_val(brd), .pin_in(pin));
  // Clock of 25 ns, and a ceiling on cycles so that a hang still ends the run.
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  // Random bytes from a shift register, so every run repeats.
  function automatic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    rnd = lf;
  endfunction
  // True when the edge from o to n is one the edge field selects.
  function automatic fire(input o, input n);
    fire = (eg[0] & ~o & n) | (eg[1] & o & ~n);
  endfunction
  // Expected enable and level of all pins, given the realtime pins rt.
  function automatic [15:0] drive(input [7:0] rt);
    reg [7:0] oe;
    begin
      oe = (rt & sdr) | (~rt & (ps | dir));
      drive = {oe, oe & ((rt & sd) | (~rt & ps & pg) | (~rt & ~ps & lat))};
    end
  endfunction
  task automatic cmp(input [7:0] g, input [7:0] e, input string m);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
      end
    end
  endtask
  task automatic cmpr(input [1:0] g, input [1:0] e);
    cmp({6'h00, g}, {6'h00, e}, "response");
  endtask
  // Bus write: valids stay up until each is taken, bready until the answer.
  task automatic axw(input [7:0] a, input [7:0] d, input [1:0] e);
    reg pa, pw;
    begin
      @(posedge mclk);
      awa <= a;
      wd <= {24'h000000, d};
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      pa = 1'h1;
      pw = 1'h1;
      while (pa || pw) begin
        @(posedge mclk);
        if (pa && awr) begin
          pa = 1'h0;
          awv <= 1'h0;
        end
        if (pw && wr) begin
          pw = 1'h0;
          wv <= 1'h0;
        end
      end
      while (!bv) @(posedge mclk);
      bry <= 1'h0;
      cmpr(br, e);
    end
  endtask
  task automatic axr(input [7:0] a, output [7:0] d, output [1:0] r);
    begin
      @(posedge mclk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do @(posedge mclk); while (!arr);
      arv <= 1'h0;
      while (!rv) @(posedge mclk);
      d = rd[7:0];
      r = rr;
      rry <= 1'h0;
    end
  endtask
  // Write a register and follow it in the model; general bits copy into shadows.
  task automatic put(input [7:0] a, input [7:0] d);
    reg [7:0] g;
    begin
      axw(a, d, `P7G_RESP_OKAY);
      g = ~rm;
      case (a)
        `P7G_ADDR_PATTERN_GEN_SELECT: ps = d;
        `P7G_ADDR_REALTIME_MODE: rm = d | 8'h0F;
        `P7G_ADDR_PIN_DIRECTION: dir = d;
        `P7G_ADDR_PORT_DATA_LATCH: lat = d;
        `P7G_ADDR_TRIGGER_SOURCE: src = d | 8'h0F;
        default: eg = d[1:0];
      endcase
      if (a == `P7G_ADDR_PORT_DATA_LATCH) sd = (g & lat) | (~g & sd);
      if (a == `P7G_ADDR_PIN_DIRECTION) sdr = (g & dir) | (~g & sdr);
    end
  endtask
  task automatic rdc(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    reg [1:0] r;
    begin
      axr(a, d, r);
      cmpr(r, `P7G_RESP_OKAY);
      cmp(d, e, "register");
    end
  endtask
  // Let pins settle, then check them and the data readback.
  task automatic look;
    reg [15:0] x;
    reg [7:0]  k, d;
    reg [1:0]  r;
    begin
      x = drive(rm & 8'hF0);
      k = (rm & 8'hF0) | dir;
      repeat (8) @(posedge mclk);
      cmp(poe, x[15:8], "enable");
      cmp(po & poe, x[7:0], "level");
      axr(`P7G_ADDR_PORT_DATA_LATCH, d, r);
      cmp(d, (k & lat) | (~k & (x[7:0] | (~x[15:8] & brd))), "readback");
    end
  endtask
  // Move the trigger lines; selected edges load the shadows of realtime pins.
  task automatic trig(input e, input h);
    reg [7:0] m;
    begin
      @(posedge mclk);
      m = rm & 8'hF0 & ((~src & {8{fire(ext, e)}}) | (src & {8{fire(head_switch_trigger, h)}}));
      ext <= e;
      head_switch_trigger <= h;
      sd = (m & lat) | (~m & sd);
      sdr = (m & dir) | (~m & sdr);
      look;
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    rdc(`P7G_ADDR_PATTERN_GEN_SELECT, 8'h00);
    rdc(`P7G_ADDR_REALTIME_MODE, 8'h0F);
    rdc(`P7G_ADDR_PIN_DIRECTION, 8'hFF);
    rdc(`P7G_ADDR_TRIGGER_SOURCE, 8'h0F);
    rdc(`P7G_ADDR_TRIGGER_EDGE, 8'hFC);
    look;
    $display("test reset values done");
    for (i = 0; i < 10; i = i + 1) begin
      pg <= rnd();
      brd <= rnd();
      put(`P7G_ADDR_PATTERN_GEN_SELECT, rnd());
      put(`P7G_ADDR_PIN_DIRECTION, rnd());
      put(`P7G_ADDR_PORT_DATA_LATCH, rnd());
      put(`P7G_ADDR_REALTIME_MODE, rnd());
      put(`P7G_ADDR_TRIGGER_SOURCE, rnd());
      put(`P7G_ADDR_TRIGGER_EDGE, rnd());
      rdc(`P7G_ADDR_REALTIME_MODE, rm);
      rdc(`P7G_ADDR_TRIGGER_SOURCE, src);
      rdc(`P7G_ADDR_TRIGGER_EDGE, {6'h3F, eg});
      look;
    end
    $display("test random modes done");
    put(`P7G_ADDR_REALTIME_MODE, 8'h00);
    put(`P7G_ADDR_TRIGGER_SOURCE, 8'h30);
    put(`P7G_ADDR_PATTERN_GEN_SELECT, 8'hFF);
    put(`P7G_ADDR_REALTIME_MODE, 8'hF0);
    look;
    for (i = 0; i < 16; i = i + 1) begin
      put(`P7G_ADDR_TRIGGER_EDGE, {6'h00, i[3:2]});
      put(`P7G_ADDR_PORT_DATA_LATCH, rnd());
      put(`P7G_ADDR_PIN_DIRECTION, rnd());
      trig(~ext, head_switch_trigger ^ i[1]);
    end
    $display("test realtime triggers done");
    for (i = 1; i < 6; i = i + 1) begin
      pwr <= i[2:0];
      repeat (8) @(posedge mclk);
      if (i == 2 || i == 3) cmp(poe, 8'h00, "standby");
      if (i == 4) look;
      if (i == 4) rdc(`P7G_ADDR_POWER_STATE, 8'h04);
      if (i == 1 || i == 5) begin
        snap = {poe, po};
        put(`P7G_ADDR_PATTERN_GEN_SELECT, ~ps);
        put(`P7G_ADDR_PORT_DATA_LATCH, ~lat);
        cmp(po, snap[7:0], "held level");
        cmp(poe, snap[15:8], "held enable");
      end
      pwr <= `P7G_PWR_ACTIVE;
      look;
    end
    $display("test power states done");
    axw(8'h1C, rnd(), `P7G_RESP_SLVERR);
    axr(8'h1C, snap[7:0], snap[9:8]);
    cmpr(snap[9:8], `P7G_RESP_SLVERR);
    cmp(snap[7:0], 8'h00, "unmapped read");
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule

// ==== inc/p7g_consts.vh ====
// Constants for the port-7 general I/O block with realtime outputs.
// Assumes inclusion by bare name from the rtl files.
`ifndef P7G_CONSTS_VH
`define P7G_CONSTS_VH
// ****************************************
// Register byte addresses (AXI4-Lite)
// ****************************************
`define P7G_ADDR_PATTERN_GEN_SELECT  8'h00
`define P7G_ADDR_REALTIME_MODE       8'h04
`define P7G_ADDR_PIN_DIRECTION       8'h08
`define P7G_ADDR_PORT_DATA_LATCH     8'h0C
`define P7G_ADDR_TRIGGER_SOURCE      8'h10
`define P7G_ADDR_TRIGGER_EDGE        8'h14
`define P7G_ADDR_POWER_STATE         8'h18
// ****************************************
// Reset values and fixed bits
// ****************************************
`define P7G_RST_PATTERN_GEN_SELECT   8'h00
`define P7G_RST_REALTIME_MODE        8'h0F
`define P7G_RST_PIN_DIRECTION        8'h00
`define P7G_RST_PORT_DATA_LATCH      8'h00
`define P7G_RST_TRIGGER_SOURCE       8'h0F
`define P7G_RST_TRIGGER_EDGE         8'hFC
`define P7G_RST_POWER_STATE          3'h0
`define P7G_FIXED_LOW_NIBBLE         4'hF
`define P7G_FIXED_EDGE_HIGH          6'h3F
`define P7G_WRITE_ONLY_READ          8'hFF
// ****************************************
// Field positions and encodings
// ****************************************
`define P7G_UPPER_LSB                4
`define P7G_EDGE_OFF                 2'h0
`define P7G_EDGE_RISE                2'h1
`define P7G_EDGE_FALL                2'h2
`define P7G_EDGE_BOTH                2'h3
// Power states: active, sleep, standby, watch, subactive, subsleep.
`define P7G_PWR_ACTIVE               3'h0
`define P7G_PWR_SLEEP                3'h1
`define P7G_PWR_STANDBY              3'h2
`define P7G_PWR_WATCH                3'h3
`define P7G_PWR_SUBACTIVE            3'h4
`define P7G_PWR_SUBSLEEP             3'h5
// AXI responses.
`define P7G_RESP_OKAY                2'h0
`define P7G_RESP_SLVERR              2'h2
`endif

// ==== rtl/p7g_edge_detect.v ====
// Trigger edge detector producing a single-cycle shadow-load pulse.
// Assumes its input is already synchronous to the clock.
`include "p7g_consts.vh"
module p7g_edge_detect (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Trigger
  input  wire       trig,
  input  wire [1:0] edge_sel,
  output wire       pulse
);
  reg prev;

  // Previous level, to find transitions.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= trig;
    end
  end

  // Edge decode: off, rising, falling or both.
  assign pulse = ((edge_sel == `P7G_EDGE_RISE) && trig && !prev) ||
                 ((edge_sel == `P7G_EDGE_FALL) && !trig && prev) ||
                 ((edge_sel == `P7G_EDGE_BOTH) && (trig != prev));
endmodule

// ==== rtl/p7g_port.v ====
// Port-7 general I/O with realtime outputs on pins 7..4, AXI4-Lite slave.
// Assumes a single 40 MHz MCLK; the pins, external trigger and power-state input
// come from outside the clock domain and are synchronised here. The pattern
// generator is assumed to run on MCLK, so its outputs are used as they come.
`include "p7g_consts.vh"
module p7g_port (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RST_N,
  // AXI4-Lite write address
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // Port pins
  input  wire [7:0]  PORT_PIN_IN,
  output reg  [7:0]  PORT_PIN_OUT,
  output reg  [7:0]  PORT_PIN_OE,
  // Alternate sources
  input  wire [7:0]  PATTERN_GENERATOR_OUTPUT,
  input  wire        EXTERNAL_TRIGGER_PIN,
  input  wire        HEAD_SWITCH_TRIGGER,
  // Power state from the low-power controller
  input  wire [2:0]  POWER_STATE
);
  // ****************************************
  // Registers and state
  // ****************************************
  reg  [7:0] pattern_gen_select;
  reg  [3:0] realtime_mode_select;
  reg  [7:0] pin_direction;
  reg  [7:0] port_data_latch;
  reg  [3:0] trigger_source_select;
  reg  [1:0] trigger_edge_select;
  reg  [3:0] output_data_shadow;
  reg  [3:0] direction_shadow;
  reg  [7:0] aw_addr;
  reg        aw_have;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;
  reg        w_have;
  wire [7:0] pin_sync;
  wire [2:0] pwr_sync;
  wire       ext_sync;
  wire       hsw_sync;
  wire       ext_pulse;
  wire       hsw_pulse;
  wire       wr_fire;
  wire       wr_lane0;
  wire [7:0] wbyte;
  reg  [7:0] read_data;
  reg        read_ok;
  reg  [7:0] data_read;
  reg  [7:0] next_pin_out;
  reg  [7:0] next_pin_oe;
  wire       pins_float;
  wire       pins_hold;
  wire       latch_wr;
  wire       dir_wr;
  wire [7:0] rt_sel;
  wire [7:0] rt_data;
  wire [7:0] rt_dir;

  // Reset images of the registers. Only the writable parts are stored, so the
  // fixed-one bits are sliced off here and added back on the read path.
  localparam [7:0] rst_rt_mode   = `P7G_RST_REALTIME_MODE;
  localparam [7:0] rst_trig_src  = `P7G_RST_TRIGGER_SOURCE;
  localparam [7:0] rst_trig_edge = `P7G_RST_TRIGGER_EDGE;

  // ****************************************
  // Input synchronisation
  // ****************************************
  // Pins, trigger and power state are asynchronous to MCLK.
  // The head-switch input may be on MCLK already; synchronising it costs only
  // latency and keeps both trigger sources aligned.
  p7g_sync2 #(.W(13)) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     ({POWER_STATE, HEAD_SWITCH_TRIGGER, EXTERNAL_TRIGGER_PIN, PORT_PIN_IN}),
    .q     ({pwr_sync, hsw_sync, ext_sync, pin_sync})
  );

  // One edge detector per trigger source; each of pins 7..4 then picks one.
  // Changing the edge field between edges gives no pulse, because each
  // detector compares the synchronised level with its own previous sample.
  p7g_edge_detect u_ext_edge (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .trig     (ext_sync),
    .edge_sel (trigger_edge_select),
    .pulse    (ext_pulse)
  );

  p7g_edge_detect u_hsw_edge (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .trig     (hsw_sync),
    .edge_sel (trigger_edge_select),
    .pulse    (hsw_pulse)
  );

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Address and data are caught independently; the write fires when both are held
  // and no response is pending. A held slot refuses a new address or data beat until
  // the write fires, so at most one write waits behind a pending response, and the
  // response always follows both halves.
  assign wr_fire  = aw_have && w_have && !S_AXI_BVALID;
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wbyte    = w_data[7:0];

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `P7G_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_have && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_have && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        // Unmapped addresses answer with a slave error.
        case (aw_addr)
          `P7G_ADDR_PATTERN_GEN_SELECT, `P7G_ADDR_REALTIME_MODE,
          `P7G_ADDR_PIN_DIRECTION, `P7G_ADDR_PORT_DATA_LATCH,
          `P7G_ADDR_TRIGGER_SOURCE, `P7G_ADDR_TRIGGER_EDGE,
          `P7G_ADDR_POWER_STATE: begin
            S_AXI_BRESP <= `P7G_RESP_OKAY;
          end
          default: begin
            S_AXI_BRESP <= `P7G_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  assign latch_wr = wr_lane0 && (aw_addr == `P7G_ADDR_PORT_DATA_LATCH);
  assign dir_wr   = wr_lane0 && (aw_addr == `P7G_ADDR_PIN_DIRECTION);

  // Only byte lane 0 carries register bits; fixed-one bits are not stored.
  // A write with strobe bit 0 clear, or to an unmapped address, stores nothing.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pattern_gen_select    <= `P7G_RST_PATTERN_GEN_SELECT;
      realtime_mode_select  <= rst_rt_mode[7:4];
      pin_direction         <= `P7G_RST_PIN_DIRECTION;
      port_data_latch       <= `P7G_RST_PORT_DATA_LATCH;
      trigger_source_select <= rst_trig_src[7:4];
      trigger_edge_select   <= rst_trig_edge[1:0];
    end else if (wr_lane0) begin
      case (aw_addr)
        `P7G_ADDR_PATTERN_GEN_SELECT: pattern_gen_select <= wbyte;
        `P7G_ADDR_REALTIME_MODE:      realtime_mode_select <= wbyte[7:4];
        `P7G_ADDR_PIN_DIRECTION:      pin_direction <= wbyte;
        `P7G_ADDR_PORT_DATA_LATCH:    port_data_latch <= wbyte;
        `P7G_ADDR_TRIGGER_SOURCE:     trigger_source_select <= wbyte[7:4];
        `P7G_ADDR_TRIGGER_EDGE:       trigger_edge_select <= wbyte[1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Shadow latches for pins 7..4
  // ****************************************
  // A trigger in realtime mode loads both shadows; in general I/O use each
  // shadow follows its register write so the pair behaves as one register.
  // Setting a realtime bit keeps the shadow of the last general write, so the
  // pin takes that level and enable until the first trigger arrives.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_shadow
      wire load = trigger_source_select[g] ? hsw_pulse : ext_pulse;
      always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          output_data_shadow[g] <= 1'b0;
          direction_shadow[g]   <= 1'b0;
        end else if (realtime_mode_select[g]) begin
          if (load) begin
            output_data_shadow[g] <= port_data_latch[g+4];
            direction_shadow[g]   <= pin_direction[g+4];
          end
        end else begin
          if (latch_wr) begin
            output_data_shadow[g] <= wbyte[g+4];
          end
          if (dir_wr) begin
            direction_shadow[g] <= wbyte[g+4];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Pin function select and data readback
  // ****************************************
  // Full-width views of the realtime controls; pins 3..0 have no realtime
  // mode, so their slots are tied to zero.
  assign rt_sel  = {realtime_mode_select, 4'h0};
  assign rt_data = {output_data_shadow, 4'h0};
  assign rt_dir  = {direction_shadow, 4'h0};

  // Priority on the upper pins: realtime, then pattern generator, then I/O.
  integer i;
  always @* begin
    next_pin_out = 8'h00;
    next_pin_oe  = 8'h00;
    data_read    = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      data_read[i] = pin_direction[i] ? port_data_latch[i] : pin_sync[i];
      if (rt_sel[i]) begin
        next_pin_out[i] = rt_data[i];
        next_pin_oe[i]  = rt_dir[i];
        data_read[i]    = port_data_latch[i];
      end else if (pattern_gen_select[i]) begin
        next_pin_out[i] = PATTERN_GENERATOR_OUTPUT[i];
        next_pin_oe[i]  = 1'b1;
      end else begin
        next_pin_out[i] = port_data_latch[i];
        next_pin_oe[i]  = pin_direction[i];
      end
    end
  end

  // Standby and watch float the pins; sleep and subsleep freeze them.
  // The power state passes the same two flops as the pins, so a change takes
  // effect on the pins three edges after it is presented.
  assign pins_float = (pwr_sync == `P7G_PWR_STANDBY) || (pwr_sync == `P7G_PWR_WATCH);
  assign pins_hold  = (pwr_sync == `P7G_PWR_SLEEP) || (pwr_sync == `P7G_PWR_SUBSLEEP);

  // Pins are registered; reset and standby/watch release them.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PORT_PIN_OUT <= 8'h00;
      PORT_PIN_OE  <= 8'h00;
    end else if (pins_float) begin
      PORT_PIN_OUT <= 8'h00;
      PORT_PIN_OE  <= 8'h00;
    end else if (!pins_hold) begin
      PORT_PIN_OUT <= next_pin_out;
      PORT_PIN_OE  <= next_pin_oe;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  // Read decode works on the live address; it is sampled only at the edge at
  // which the address is taken. The direction register reads back as ones.
  always @* begin
    read_ok   = 1'b1;
    read_data = 8'h00;
    case (S_AXI_ARADDR)
      `P7G_ADDR_PATTERN_GEN_SELECT: read_data = pattern_gen_select;
      `P7G_ADDR_REALTIME_MODE:   read_data = {realtime_mode_select, `P7G_FIXED_LOW_NIBBLE};
      `P7G_ADDR_PIN_DIRECTION:   read_data = `P7G_WRITE_ONLY_READ;
      `P7G_ADDR_PORT_DATA_LATCH: read_data = data_read;
      `P7G_ADDR_TRIGGER_SOURCE:  read_data = {trigger_source_select, `P7G_FIXED_LOW_NIBBLE};
      `P7G_ADDR_TRIGGER_EDGE:    read_data = {`P7G_FIXED_EDGE_HIGH, trigger_edge_select};
      `P7G_ADDR_POWER_STATE:     read_data = {5'h00, pwr_sync};
      default:                   read_ok   = 1'b0;
    endcase
  end

  // One read at a time; the answer comes the cycle after the address is taken.
  // A new address is refused while a read answer still waits for RREADY.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `P7G_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h000000, read_data};
        S_AXI_RRESP  <= read_ok ? `P7G_RESP_OKAY : `P7G_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// ==== rtl/p7g_sync2.v ====
// Two-flop synchroniser bank for levels arriving from outside MCLK.
// Assumes the inputs are quasi-static levels relative to MCLK.
module p7g_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
